// ### logic/pabm_pkg.sv
// shared constants, register map and carrier types of the port a/b pin mux
// assumes one 100 MHz clock, an axi4-lite register bus and same-clock peripherals
// Functional notes
// [R1] pull-up disable bit kills every port pull-up
// [R2] special register resets zero, bit 4 reads zero
// [R3] port a pads feed converter channels, no overrides
// [R4] software keeps port a outputs still during conversion
// [R5] clock pin forced input as spi slave
// [R6] miso pin forced input as spi master
// [R7] mosi pin forced input as spi slave
// [R8] select pin forced input as spi slave
// [R9] slave spi active only while select low
// [R10] forced spi input pull-up follows latch bit
// [R11] compare output reaches pad only when output
// [R12] software sets comparator pins input, no pull-up
// [R13] port b bit 2 routes external interrupt two
// [R14] port b bit 1 feeds timer one count
// [R15] port b bit 0 feeds timer zero, usart clock
// [R16] pull-up override else direction/latch/disable decode
// [R17] direction override else direction bit drives enable
// [R18] value override else latch drives pad value
// [R19] input enable override else sleep state decides
// [R20] spi off leaves serial pins plain io
package pabm_pkg;

  localparam int          PABM_AW          = 8;      // register address width
  localparam logic [7:0]  PABM_SFR_OFF     = 8'h00;  // special_function_io
  localparam logic [7:0]  PABM_DIR_A_OFF   = 8'h04;  // port a direction bits
  localparam logic [7:0]  PABM_LAT_A_OFF   = 8'h08;  // port a output latch bits
  localparam logic [7:0]  PABM_DIR_B_OFF   = 8'h0C;  // port b direction bits
  localparam logic [7:0]  PABM_LAT_B_OFF   = 8'h10;  // port b output latch bits
  localparam logic [7:0]  PABM_PIN_A_OFF   = 8'h14;  // port a pin levels, read only
  localparam logic [7:0]  PABM_PIN_B_OFF   = 8'h18;  // port b pin levels, read only
  localparam logic [7:0]  PABM_SFR_RST     = 8'h00;  // special register after reset
  localparam logic [7:0]  PABM_PORT_RST    = 8'h00;  // direction and latch after reset
  localparam logic [7:0]  PABM_SFR_WMASK   = 8'hEF;  // bit 4 is read only zero
  localparam int          PABM_PULLUP_OFF  = 2;      // global_pullup_disable position
  localparam int          PABM_RO_BIT      = 4;      // read-only bit position
  localparam logic [1:0]  PABM_RESP_OKAY   = 2'h0;   // axi okay
  localparam logic [1:0]  PABM_RESP_SLVERR = 2'h2;   // axi slave error

  // override bundle of one pin
  typedef struct packed {
    logic pullup_override_en;         // pull-up taken from the value below
    logic pullup_override_val;        // forced pull-up level
    logic direction_override_en;      // driver enable taken from below
    logic direction_override_val;     // forced driver enable
    logic value_override_en;          // pad value taken from below
    logic value_override_val;         // forced pad value
    logic input_enable_override_en;   // input enable taken from below
    logic input_enable_override_val;  // forced input enable
  } pabm_ovr_s;

  // controls arriving from the internal peripherals
  typedef struct packed {
    logic spi_enable;       // spi switched on
    logic spi_master;       // spi in master role
    logic spi_clk_out;      // master serial clock
    logic spi_slave_out;    // slave data out
    logic spi_master_out;   // master data out
    logic compare_en;       // timer zero compare output enabled
    logic compare_out;      // timer_zero_compare_out level
    logic irq_two_en;       // external_irq_two enabled
    logic usart_sync;       // usart synchronous mode
    logic usart_clk_out;    // usart clock when driven
    logic sleep_active;     // deep sleep clamps inputs
  } pabm_periph_s;

endpackage : pabm_pkg

// ### logic/pabm_sync2.sv
// two flip-flop synchroniser for a vector of pad inputs
// assumes the inputs are asynchronous to aclk
`timescale 1ns/1ns
module pabm_sync2 #(
  parameter int WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second stage

  // two stages, cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : pabm_sync2

// ### logic/pabm_pin_cell.sv
// generic override logic of one port pin
// assumes overrides come from same-clock peripheral logic
`timescale 1ns/1ns
module pabm_pin_cell (
  input  wire logic               pin_direction_bit,
  input  wire logic               pin_output_latch_bit,
  input  wire logic               global_pullup_disable,
  input  wire logic               sleep_active,
  input  wire pabm_pkg::pabm_ovr_s ovr,
  output logic                    drive_en,
  output logic                    drive_val,
  output logic                    pullup_en,
  output logic                    input_en
);

  // pull-up: override or {dir, latch, disable} == 0b010
  always_comb begin
    if (ovr.pullup_override_en) begin
      pullup_en = ovr.pullup_override_val;  // R16
    end else begin
      pullup_en = !pin_direction_bit && pin_output_latch_bit
                  && !global_pullup_disable;  // R16 R1
    end
  end

  // output driver enable
  always_comb begin
    drive_en = ovr.direction_override_en ? ovr.direction_override_val
                                         : pin_direction_bit;  // R17
  end

  // pad value while driven
  always_comb begin
    drive_val = ovr.value_override_en ? ovr.value_override_val
                                      : pin_output_latch_bit;  // R18
  end

  // digital input enable, clamped in deep sleep
  always_comb begin
    input_en = ovr.input_enable_override_en ? ovr.input_enable_override_val
                                            : !sleep_active;  // R19
  end

endmodule : pabm_pin_cell

// ### logic/pabm_top.sv
// port a/b pin mux with axi4-lite register slave
// assumes pads asynchronous, peripheral controls on aclk
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module pabm_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [7:0]           pad_a_in,
  output logic [7:0]                pad_a_out,
  output logic [7:0]                pad_a_oe,
  output logic [7:0]                pad_a_pullup,
  input  wire logic [7:0]           pad_b_in,
  output logic [7:0]                pad_b_out,
  output logic [7:0]                pad_b_oe,
  output logic [7:0]                pad_b_pullup,
  input  wire pabm_pkg::pabm_periph_s periph,
  output logic [7:0]                converter_channel_in,
  output logic                      comparator_positive_in,
  output logic                      comparator_negative_in,
  output logic                      spi_clk_in,
  output logic                      spi_master_in,
  output logic                      spi_slave_in,
  output logic                      spi_select_in,
  output logic                      spi_slave_active,
  output logic                      external_irq_two,
  output logic                      timer_one_count_in,
  output logic                      timer_zero_count_in,
  output logic                      usart_ext_clock
);

  logic [7:0]          special_function_io_reg;  // sfr storage
  logic [7:0]          dir_a_reg;                // port a direction
  logic [7:0]          lat_a_reg;                // port a latch
  logic [7:0]          dir_b_reg;                // port b direction
  logic [7:0]          lat_b_reg;                // port b latch
  logic                aw_held_reg;              // write address captured
  logic                w_held_reg;               // write data captured
  logic [7:0]          awaddr_reg;               // captured write address
  logic [7:0]          wdata_reg;                // captured low byte
  logic                wstrb0_reg;               // captured lane 0 strobe
  logic                bvalid_reg;               // write response pending
  logic [1:0]          bresp_reg;                // write response code
  logic                rvalid_reg;               // read response pending
  logic [31:0]         rdata_reg;                // read data
  logic [1:0]          rresp_reg;                // read response code
  logic [15:0]         pad_sync;                 // synchronised pads, b high
  logic [15:0]         din_reg;                  // gated digital inputs
  logic [15:0]         die_all;                  // input enables
  logic [15:0]         oe_all;                   // driver enables
  logic [15:0]         val_all;                  // driver values
  logic [15:0]         pu_all;                   // pull-up enables
  logic [15:0]         dir_all;                  // direction bits, b high
  logic [15:0]         lat_all;                  // latch bits, b high
  logic [15:0]         pad_out_reg;              // registered pad value
  logic [15:0]         pad_oe_reg;               // registered driver enable
  logic [15:0]         pad_pu_reg;               // registered pull-up
  logic                slave_active_reg;         // slave spi selected
  logic                pullup_off;               // global_pullup_disable
  logic                spi_slave;                // spi on, slave role
  logic                spi_mstr;                 // spi on, master role
  logic                do_write;                 // both write halves present
  pabm_pkg::pabm_ovr_s ovr_all [16];             // per-pin overrides

  assign pullup_off = special_function_io_reg[pabm_pkg::PABM_PULLUP_OFF];
  assign spi_slave = periph.spi_enable && !periph.spi_master;
  assign spi_mstr  = periph.spi_enable && periph.spi_master;
  assign dir_all   = {dir_b_reg, dir_a_reg};
  assign lat_all   = {lat_b_reg, lat_a_reg};
  assign do_write  = aw_held_reg && w_held_reg && !bvalid_reg;

  // axi handshake outputs
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // capture write address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, error for unmapped or read-only words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pabm_pkg::PABM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      case (awaddr_reg)
        pabm_pkg::PABM_SFR_OFF,
        pabm_pkg::PABM_DIR_A_OFF,
        pabm_pkg::PABM_LAT_A_OFF,
        pabm_pkg::PABM_DIR_B_OFF,
        pabm_pkg::PABM_LAT_B_OFF: bresp_reg <= pabm_pkg::PABM_RESP_OKAY;
        default:                  bresp_reg <= pabm_pkg::PABM_RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register stores, lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      special_function_io_reg <= pabm_pkg::PABM_SFR_RST;  // R2
      dir_a_reg               <= pabm_pkg::PABM_PORT_RST;
      lat_a_reg               <= pabm_pkg::PABM_PORT_RST;
      dir_b_reg               <= pabm_pkg::PABM_PORT_RST;
      lat_b_reg               <= pabm_pkg::PABM_PORT_RST;
    end else if (do_write && wstrb0_reg) begin
      case (awaddr_reg)
        pabm_pkg::PABM_SFR_OFF:   begin
          special_function_io_reg <= wdata_reg & pabm_pkg::PABM_SFR_WMASK;  // R2
        end
        pabm_pkg::PABM_DIR_A_OFF: dir_a_reg <= wdata_reg;
        pabm_pkg::PABM_LAT_A_OFF: lat_a_reg <= wdata_reg;
        pabm_pkg::PABM_DIR_B_OFF: dir_b_reg <= wdata_reg;
        pabm_pkg::PABM_LAT_B_OFF: lat_b_reg <= wdata_reg;
        default:                  ;
      endcase
    end
  end

  // read channel, registered data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pabm_pkg::PABM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= pabm_pkg::PABM_RESP_OKAY;
      case (s_axi_araddr)
        pabm_pkg::PABM_SFR_OFF:   rdata_reg <= {24'h00_0000, special_function_io_reg};
        pabm_pkg::PABM_DIR_A_OFF: rdata_reg <= {24'h00_0000, dir_a_reg};
        pabm_pkg::PABM_LAT_A_OFF: rdata_reg <= {24'h00_0000, lat_a_reg};
        pabm_pkg::PABM_DIR_B_OFF: rdata_reg <= {24'h00_0000, dir_b_reg};
        pabm_pkg::PABM_LAT_B_OFF: rdata_reg <= {24'h00_0000, lat_b_reg};
        pabm_pkg::PABM_PIN_A_OFF: rdata_reg <= {24'h00_0000, din_reg[7:0]};
        pabm_pkg::PABM_PIN_B_OFF: rdata_reg <= {24'h00_0000, din_reg[15:8]};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= pabm_pkg::PABM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // all pins plain, port a stays so; slave forces clk, mosi, select in, master miso
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      ovr_all[k] = '0;  // R3 R20
    end
    ovr_all[15].pullup_override_en        = spi_slave;                    // R5
    ovr_all[15].direction_override_en     = spi_slave;                    // R5
    ovr_all[15].pullup_override_val       = lat_b_reg[7] && !pullup_off;  // R10
    ovr_all[15].value_override_en         = spi_mstr;
    ovr_all[15].value_override_val        = periph.spi_clk_out;
    ovr_all[14].pullup_override_en        = spi_mstr;                     // R6
    ovr_all[14].direction_override_en     = spi_mstr;                     // R6
    ovr_all[14].pullup_override_val       = lat_b_reg[6] && !pullup_off;  // R10
    ovr_all[14].value_override_en         = spi_slave;
    ovr_all[14].value_override_val        = periph.spi_slave_out;
    ovr_all[13].pullup_override_en        = spi_slave;                    // R7
    ovr_all[13].direction_override_en     = spi_slave;                    // R7
    ovr_all[13].pullup_override_val       = lat_b_reg[5] && !pullup_off;  // R10
    ovr_all[13].value_override_en         = spi_mstr;
    ovr_all[13].value_override_val        = periph.spi_master_out;
    ovr_all[12].pullup_override_en        = spi_slave;                    // R8
    ovr_all[12].direction_override_en     = spi_slave;                    // R8
    ovr_all[12].pullup_override_val       = lat_b_reg[4] && !pullup_off;  // R10
    ovr_all[11].value_override_en         = periph.compare_en;            // R11
    ovr_all[11].value_override_val        = periph.compare_out;           // R11
    ovr_all[10].input_enable_override_en  = periph.irq_two_en;            // R13
    ovr_all[10].input_enable_override_val = 1'b1;                         // R13
    ovr_all[8].value_override_en          = periph.usart_sync;            // R15
    ovr_all[8].value_override_val         = periph.usart_clk_out;         // R15
  end

  // one override cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pin
      pabm_pin_cell u_cell (
        .pin_direction_bit     (dir_all[gi]),
        .pin_output_latch_bit  (lat_all[gi]),
        .global_pullup_disable (pullup_off),
        .sleep_active          (periph.sleep_active),
        .ovr                   (ovr_all[gi]),
        .drive_en              (oe_all[gi]),
        .drive_val             (val_all[gi]),
        .pullup_en             (pu_all[gi]),
        .input_en              (die_all[gi])
      );
    end
  endgenerate

  // pad inputs into the clock domain
  pabm_sync2 #(
    .WIDTH (16)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pad_b_in, pad_a_in}),
    .sync_out (pad_sync)
  );

  // registered pad controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_reg <= 16'h0000;
      pad_oe_reg  <= 16'h0000;
      pad_pu_reg  <= 16'h0000;
    end else begin
      pad_out_reg <= val_all;
      pad_oe_reg  <= oe_all;
      pad_pu_reg  <= pu_all;  // R1
    end
  end

  // gated digital inputs and slave selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_reg          <= 16'h0000;
      slave_active_reg <= 1'b0;
    end else begin
      din_reg          <= pad_sync & die_all;
      slave_active_reg <= spi_slave && !pad_sync[12];  // R9
    end
  end

  assign pad_a_out    = pad_out_reg[7:0];
  assign pad_a_oe     = pad_oe_reg[7:0];
  assign pad_a_pullup = pad_pu_reg[7:0];
  assign pad_b_out    = pad_out_reg[15:8];
  assign pad_b_oe     = pad_oe_reg[15:8];
  assign pad_b_pullup = pad_pu_reg[15:8];

  // analog paths straight from the pads
  assign converter_channel_in   = pad_a_in;     // R3
  assign comparator_positive_in = pad_b_in[2];
  assign comparator_negative_in = pad_b_in[3];

  // digital inputs to peripherals
  assign spi_clk_in          = din_reg[15];
  assign spi_master_in       = din_reg[14];
  assign spi_slave_in        = din_reg[13];
  assign spi_select_in       = din_reg[12];
  assign spi_slave_active    = slave_active_reg;  // R9
  assign external_irq_two    = din_reg[10];       // R13
  assign timer_one_count_in  = din_reg[9];        // R14
  assign timer_zero_count_in = din_reg[8];        // R15
  assign usart_ext_clock     = din_reg[8];        // R15

  // pull-up disable clears every pull-up
  property p_pullup_kill;
    @(posedge aclk) disable iff (!aresetn)
      pullup_off |=> (pad_a_pullup == 8'h00) && (pad_b_pullup == 8'h00);
  endproperty
  a_pullup_kill: assert property (p_pullup_kill) else $error("pull-up on while disabled"); // R1
  // bit 4 never stored
  property p_sfr_ro;
    @(posedge aclk) disable iff (!aresetn)
      do_write |=> special_function_io_reg[pabm_pkg::PABM_RO_BIT] == 1'b0;
  endproperty
  a_sfr_ro: assert property (p_sfr_ro) else $error("read-only bit set"); // R2
  // port a follows plain decode only
  property p_port_a_plain;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pad_a_oe == $past(dir_a_reg)) && (pad_a_out == $past(lat_a_reg))
        && (pad_a_pullup == ($past(~dir_a_reg & lat_a_reg) & {8{!$past(pullup_off)}}));
  endproperty
  a_port_a_plain: assert property (p_port_a_plain) else $error("port a overridden"); // R3
  // slave role releases clock, mosi and select pins
  property p_clk_slave_in;
    @(posedge aclk) disable iff (!aresetn)
      spi_slave |=> !pad_b_oe[7] && !pad_b_oe[5] && !pad_b_oe[4];
  endproperty
  a_clk_slave_in: assert property (p_clk_slave_in) else $error("slave pin driven"); // R5
  // master role releases miso pin
  property p_miso_master_in;
    @(posedge aclk) disable iff (!aresetn)
      spi_mstr |=> !pad_b_oe[6];
  endproperty
  a_miso_master_in: assert property (p_miso_master_in) else $error("miso driven"); // R6
  // master role keeps mosi under direction bit, driving spi data
  property p_mosi_master;
    @(posedge aclk) disable iff (!aresetn)
      spi_mstr && dir_b_reg[5] |=> pad_b_oe[5] && pad_b_out[5] == $past(periph.spi_master_out);
  endproperty
  a_mosi_master: assert property (p_mosi_master) else $error("mosi not driven"); // R7
  // select pin under direction bit as master
  property p_sel_master;
    @(posedge aclk) disable iff (!aresetn)
      spi_mstr |=> pad_b_oe[4] == $past(dir_b_reg[4]);
  endproperty
  a_sel_master: assert property (p_sel_master) else $error("select direction wrong"); // R8
  // slave active only after low select
  property p_slave_active;
    @(posedge aclk) disable iff (!aresetn)
      spi_slave_active |-> !$past(pad_sync[12]) && $past(spi_slave);
  endproperty
  a_slave_active: assert property (p_slave_active) else $error("slave active wrongly"); // R9
  // forced input pull-up tracks latch
  property p_forced_pullup;
    @(posedge aclk) disable iff (!aresetn)
      spi_slave |=> pad_b_pullup[7] == $past(lat_b_reg[7] && !pullup_off);
  endproperty
  a_forced_pullup: assert property (p_forced_pullup) else $error("forced pull-up wrong"); // R10
  // compare output only with direction set
  property p_compare_out;
    @(posedge aclk) disable iff (!aresetn)
      periph.compare_en |=> (pad_b_oe[3] == $past(dir_b_reg[3]))
        && (pad_b_out[3] == $past(periph.compare_out));
  endproperty
  a_compare_out: assert property (p_compare_out) else $error("compare pin wrong"); // R11
  // spi off gives plain io on serial pins
  property p_spi_off;
    @(posedge aclk) disable iff (!aresetn)
      !periph.spi_enable |=> (pad_b_oe[7:4] == $past(dir_b_reg[7:4]))
        && (pad_b_out[7:4] == $past(lat_b_reg[7:4]));
  endproperty
  a_spi_off: assert property (p_spi_off) else $error("serial pin overridden"); // R20

endmodule : pabm_top

// ### sim/pabm_periph_model.sv
// stand-in for the spi, timer and usart peripherals feeding the mux
// assumes the bench changes role just after a rising clock edge
`timescale 1ns/1ns
module pabm_periph_model (
  input  wire logic [5:0]        role,   // sleep, irq, usart, spi, master, compare
  output pabm_pkg::pabm_periph_s periph  // control levels to the mux
);
  // plain levels, the peripherals have no handshake here
  always_comb begin
    periph               = '0;
    periph.sleep_active  = role[5];
    periph.irq_two_en    = role[4];
    periph.usart_sync    = role[3];
    periph.usart_clk_out = 1'b1;
    periph.spi_enable  = role[2];
    periph.spi_master  = role[1];
    periph.compare_en  = role[0];
    periph.compare_out = 1'b1;
  end
endmodule : pabm_periph_model

// ### sim/tb_port_ab_alt_function_mux.sv
// bench for the port a/b pin mux: axi4-lite accesses, then pad checks
// assumes pad outputs settle within four edges of a register write
`timescale 1ns/1ns
module tb_port_ab_alt_function_mux;
  logic        aclk = 0, aresetn = 0;           // clock, low reset
  logic [7:0]  addr = 0, pa = 0, pb = 0, rd;    // address, pad inputs, read byte
  logic [31:0] wdata = 0, rdw;                  // write and read words
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, sact, irq, cnt1, cnt0, uclk;
  logic        cpos, cneg;                      // comparator inputs
  logic [3:0]  spi_in;                          // serial pin inputs, clock first
  logic [1:0]  bresp, rresp, rsp;               // responses
  logic [7:0]  aout, aoe, apu, bout, boe, bpu, conv; // pad side
  logic [5:0]  role = 0;                        // peripheral mode
  pabm_pkg::pabm_periph_s periph;               // peripheral controls
  int          err_count = 0, total_checks = 0; // tallies

  // free running 100 MHz clock
  always #5 aclk = ~aclk;

  pabm_periph_model per_u (.role(role), .periph(periph));
  pabm_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(addr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(addr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdw), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pad_a_in(pa), .pad_a_out(aout), .pad_a_oe(aoe),
    .pad_a_pullup(apu), .pad_b_in(pb), .pad_b_out(bout), .pad_b_oe(boe),
    .pad_b_pullup(bpu), .periph(periph), .converter_channel_in(conv),
    .comparator_positive_in(cpos), .comparator_negative_in(cneg), .spi_clk_in(spi_in[3]),
    .spi_master_in(spi_in[2]), .spi_slave_in(spi_in[1]), .spi_select_in(spi_in[0]),
    .spi_slave_active(sact), .external_irq_two(irq),
    .timer_one_count_in(cnt1), .timer_zero_count_in(cnt0), .usart_ext_clock(uclk));

  // one axi4-lite write or read, then let the pads settle
  task automatic axi(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic done;  // answer seen
    @(posedge aclk);
    addr    <= a;
    wdata   <= {24'h0, d};
    awvalid <= wr;
    wvalid  <= wr;
    bready  <= wr;
    arvalid <= !wr;
    rready  <= !wr;
    done = 1'b0;
    // wait for the answer, only the watchdog ends a hang
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (arvalid && arready) arvalid <= 0;
      if (bvalid && bready) begin
        bready <= 0;
        rsp = bresp;
        done = 1'b1;
      end
      if (rvalid && rready) begin
        rready <= 0;
        rsp = rresp;
        rd = rdw[7:0];
        done = 1'b1;
      end
    end
    repeat (4) @(posedge aclk);
  endtask : axi

  // byte compare
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // verdict and stop
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // hang guard
  initial begin
    #100000;
    err_count++;
    end_sim;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    axi(0, 8'h00, 8'h00); chk(rd, 8'h00);
    axi(1, 8'h00, 8'hFF); axi(0, 8'h00, 8'h00); chk(rd, 8'hEF);
    axi(0, 8'h40, 8'h00); chk({6'h0, rsp}, 8'h02);
    axi(1, 8'h00, 8'h00); axi(1, 8'h10, 8'hFF); chk(bpu, 8'hFF);
    axi(1, 8'h00, 8'h04); chk(bpu, 8'h00);
    axi(1, 8'h00, 8'h00);
    pa <= 8'hA5;
    axi(1, 8'h04, 8'h0F); axi(1, 8'h08, 8'h55); chk(aout, 8'h55);
    chk(aoe, 8'h0F);
    chk(apu, 8'h50);
    chk(conv, 8'hA5);
    role <= 6'b000100;
    pb <= 8'h07;
    axi(1, 8'h0C, 8'hF0); chk(boe, 8'h40);
    chk(bpu, 8'hBF);
    chk({7'h0, sact}, 8'h01);
    chk({spi_in, irq, cnt1, cnt0, uclk}, 8'h0F);
    pb <= 8'h17;
    repeat (4) @(posedge aclk);
    chk({7'h0, sact}, 8'h00);
    role <= 6'b000110;
    repeat (4) @(posedge aclk);
    chk(boe, 8'hB0);
    chk({7'h0, sact}, 8'h00);
    axi(1, 8'h10, 8'hF3); chk({6'h0, cneg, cpos}, 8'h01);
    role <= 6'b000001;
    axi(1, 8'h10, 8'h00); chk(boe, 8'hF0);
    chk(bout[7:0], 8'h08);
    axi(1, 8'h0C, 8'h00); chk(boe, 8'h00);
    role <= 6'b111000;
    axi(0, 8'h18, 8'h00); chk(rd, 8'h04);
    chk(bout, 8'h01);
    end_sim;
  end
endmodule : tb_port_ab_alt_function_mux
